// *** rtl/sar_adc_pkg.sv ***
/*
  Package for the successive-approximation converter control block:
  register offsets, field positions, reset values and timing counts.
  Assumes a 32-bit AXI4-Lite register bus, one register per word.
*/
package sar_adc_pkg;

  // Printed offsets are not word multiples: kept as indices
  localparam logic [15:0] MODE_IDX   = 16'hffc4;
  localparam logic [15:0] RESULT_IDX = 16'hffc5;
  localparam logic [15:0] START_IDX  = 16'hffc6;
  // Extra registers for the interrupt and trigger pieces
  localparam logic [15:0] IRQ_STAT_IDX = 16'hffc8;
  localparam logic [15:0] IRQ_MASK_IDX = 16'hffc9;
  localparam logic [15:0] TRIG_CFG_IDX = 16'hffca;

  // Mode register fields
  localparam int MODE_SPEED_BIT = 7;
  localparam int MODE_TRIG_BIT  = 6;
  localparam logic [7:0] MODE_RESET    = 8'h30;
  localparam logic [7:0] MODE_RSV_MASK = 8'h30;
  // Start register fields
  localparam int START_FLAG_BIT = 7;
  localparam logic [7:0] START_RESET    = 8'h7f;
  localparam logic [7:0] START_RSV_MASK = 8'h7f;
  // Trigger config: bit 0 pin function, bit 1 edge (1 = rising)
  localparam int TRIG_FUNC_BIT = 0;
  localparam int TRIG_EDGE_BIT = 1;

  // Conversion lengths in system clock periods
  localparam int CONV_LONG_CYC  = 62;
  localparam int CONV_SHORT_CYC = 31;
  localparam int RESULT_BITS    = 8;
  localparam int NUM_INPUTS     = 12;
  localparam logic [3:0] CHAN_BASE = 4'h4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** rtl/sar_approx.sv ***
/*
  Successive-approximation sequencer: one trial bit per step, the step
  rate set by a divider enable. Assumes the comparator input is already
  synchronous to aclk.
*/
`timescale 1ns/10ps
`default_nettype none

module sar_approx #(
  parameter int BITS = 8
) (
  // Clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // Control
  input  wire logic            go,
  input  wire logic            abort,
  input  wire logic            step_en,
  // Analog side
  input  wire logic            cmp_above,
  output logic [BITS-1:0]      trial,
  // Result
  output logic                 done,
  output logic [BITS-1:0]      value
);

  initial begin
    if (BITS < 2 || BITS > 16) $error("sar_approx: BITS out of range");
  end

  // All state in one struct
  typedef struct packed {
    logic            busy;
    logic [BITS-1:0] mask;
    logic [BITS-1:0] acc;
    logic            done;
  } sar_state_t;

  sar_state_t st_r;
  sar_state_t st_nxt;

  ////////////////////////////////////////////////////////////////////
  // Next state: test top bit first, keep it if input not below trial
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (abort) begin
      // Stop ends the run with no completion; the partial value stays in acc
      st_nxt.busy = 1'b0;
    end else if (go) begin
      st_nxt.busy = 1'b1;
      st_nxt.mask = {1'b1, {(BITS-1){1'b0}}};
      st_nxt.acc  = {1'b1, {(BITS-1){1'b0}}};
    end else if (st_r.busy && step_en) begin
      // Decide current bit, move to next
      if (!cmp_above) begin
        st_nxt.acc = st_r.acc & ~st_r.mask;
      end
      st_nxt.mask = st_r.mask >> 1;
      st_nxt.acc  = st_nxt.acc | (st_r.mask >> 1);
      if (st_r.mask[0]) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
    end
  end

  // Register the state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign trial = st_r.acc;
  assign done  = st_r.done;
  assign value = st_r.acc;

endmodule

`default_nettype wire

// *** rtl/sar_adc_control.sv ***
/*
  Control of an 8-bit successive-approximation converter with twelve
  multiplexed inputs, reached over AXI4-Lite. Assumes an external
  comparator and ladder driven by trial_code and input_select, and a
  trigger pin that is asynchronous to aclk.
*/
`timescale 1ns/10ps
`default_nettype none

module sar_adc_control #(
  parameter int ADDR_W = 18
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Trigger pin, asynchronous
  input  wire logic              external_trigger_pin,
  // Analog front end
  input  wire logic              cmp_above,
  output logic [7:0]             trial_code,
  output logic                   input_valid,
  output logic [3:0]             input_select,
  // Interrupt
  output logic                   irq
);

  initial begin
    if (ADDR_W < 18 || ADDR_W > 32) $error("ADDR_W out of range");
  end

  localparam int RB = sar_adc_pkg::RESULT_BITS;
  localparam int SB = sar_adc_pkg::START_FLAG_BIT;

  ////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [7:0] mode;      // Speed, trigger enable, channel
    logic       start_flag;
    logic [1:0] trig_cfg;  // Pin function, edge select
    logic       req_flag;  // Sticky completion request
    logic       req_mask;  // Completion interrupt enable
    logic [5:0] div;       // Step divider
    logic [2:0] trig_sync; // Two sync stages plus history
    logic       aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic       w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctl_state_t;

  ctl_state_t st_r;
  ctl_state_t st_nxt;
  logic [7:0] result_r;    // No reset
  logic       load_result;

  // Sequencer wires
  logic          seq_go;
  logic          seq_abort;
  logic          step_en;
  logic          seq_done;
  logic [RB-1:0] seq_value;

  ////////////////////////////////////////////////////////////////////
  // Sequencer instance
  sar_approx #(
    .BITS (RB)
  ) u_sar (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .go        (seq_go),
    .abort     (seq_abort),
    .step_en   (step_en),
    .cmp_above (cmp_above),
    .trial     (trial_code),
    .done      (seq_done),
    .value     (seq_value)
  );

  // Step period: total length split over the result bits
  localparam logic [5:0] STEP_LONG =
    6'(sar_adc_pkg::CONV_LONG_CYC / RB);
  localparam logic [5:0] STEP_SHORT =
    6'(sar_adc_pkg::CONV_SHORT_CYC / RB);

  // Lead-in before the first trial pads the split to the full length
  localparam int LEAD_LONG_I = sar_adc_pkg::CONV_LONG_CYC -
    (RB - 1) * (sar_adc_pkg::CONV_LONG_CYC / RB) - 2;
  localparam int LEAD_SHORT_I = sar_adc_pkg::CONV_SHORT_CYC -
    (RB - 1) * (sar_adc_pkg::CONV_SHORT_CYC / RB) - 2;
  localparam logic [5:0] LEAD_LONG  = 6'(LEAD_LONG_I);
  localparam logic [5:0] LEAD_SHORT = 6'(LEAD_SHORT_I);

  // Lead-ins the six-bit divider cannot count are refused
  initial begin
    if (LEAD_LONG_I < 0 || LEAD_LONG_I > 63) $error("bad lead-in");
    if (LEAD_SHORT_I < 0 || LEAD_SHORT_I > 63) $error("bad lead-in");
  end

  // Derived wires
  logic        trig_edge;
  logic        wr_fire;
  logic [15:0] wr_idx;
  logic [15:0] rd_idx;
  logic [7:0]  wbyte;
  logic [5:0]  step_len;
  logic [5:0]  lead_len;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        wr_hit;

  ////////////////////////////////////////////////////////////////////
  // Main next-state logic
  always_comb begin
    st_nxt      = st_r;
    seq_go      = 1'b0;
    seq_abort   = 1'b0;
    load_result = 1'b0;
    // Trigger synchroniser
    st_nxt.trig_sync = {st_r.trig_sync[1:0], external_trigger_pin};
    trig_edge = st_r.trig_cfg[sar_adc_pkg::TRIG_EDGE_BIT] ?
                (st_r.trig_sync[1] & ~st_r.trig_sync[2]) :
                (~st_r.trig_sync[1] & st_r.trig_sync[2]);
    // Step length and lead-in by speed select
    step_len = st_r.mode[sar_adc_pkg::MODE_SPEED_BIT] ?
               STEP_SHORT : STEP_LONG;
    lead_len = st_r.mode[sar_adc_pkg::MODE_SPEED_BIT] ?
               LEAD_SHORT : LEAD_LONG;
    step_en  = st_r.start_flag && (st_r.div == 6'h00);

    // Write channel capture
    if (s_axi_awvalid && !st_r.aw_held) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_held) begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata  = s_axi_wdata;
      st_nxt.wstrb  = s_axi_wstrb;
    end
    wr_fire = st_r.aw_held && st_r.w_held && !st_r.bvalid;
    wr_idx  = 16'(st_r.awaddr >> 2);
    wbyte   = st_r.wdata[7:0];
    wr_hit  = 1'b0;

    // Completion: load result and clear flag together
    if (seq_done && st_r.start_flag) begin
      load_result       = 1'b1;
      st_nxt.start_flag = 1'b0;
    end

    if (wr_fire) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      unique case (wr_idx)
        sar_adc_pkg::MODE_IDX: begin
          wr_hit = 1'b1;
          // Reserved bits stay one
          if (st_r.wstrb[0]) begin
            st_nxt.mode = wbyte | sar_adc_pkg::MODE_RSV_MASK;
          end
        end
        sar_adc_pkg::START_IDX: begin
          wr_hit = 1'b1;
          if (st_r.wstrb[0]) begin
            if (wbyte[SB] && !st_r.start_flag) begin
              // Software start
              st_nxt.start_flag = 1'b1;
              seq_go            = 1'b1;
            end else if (!wbyte[SB] && st_r.start_flag) begin
              // Stop: no load, no request
              // A stop on the completion edge wins over the load
              st_nxt.start_flag = 1'b0;
              seq_abort         = 1'b1;
              load_result       = 1'b0;
            end
          end
        end
        sar_adc_pkg::RESULT_IDX: begin
          wr_hit = 1'b1;
        end
        sar_adc_pkg::IRQ_STAT_IDX: begin
          wr_hit = 1'b1;
          if (st_r.wstrb[0] && wbyte[0]) begin
            st_nxt.req_flag = 1'b0;
          end
        end
        sar_adc_pkg::IRQ_MASK_IDX: begin
          wr_hit = 1'b1;
          if (st_r.wstrb[0]) begin
            st_nxt.req_mask = wbyte[0];
          end
        end
        sar_adc_pkg::TRIG_CFG_IDX: begin
          wr_hit = 1'b1;
          if (st_r.wstrb[0]) begin
            st_nxt.trig_cfg = wbyte[1:0];
          end
        end
        default: begin
          wr_hit = 1'b0;
        end
      endcase
      st_nxt.bresp = wr_hit ? sar_adc_pkg::RESP_OKAY :
                              sar_adc_pkg::RESP_SLVERR;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // External trigger start when gated on
    if (trig_edge && st_r.mode[sar_adc_pkg::MODE_TRIG_BIT] &&
        st_r.trig_cfg[sar_adc_pkg::TRIG_FUNC_BIT] &&
        !st_nxt.start_flag && !seq_abort) begin
      st_nxt.start_flag = 1'b1;
      seq_go            = 1'b1;
    end

    // Divider: lead-in on every start, then one period per trial.
    // Placed after both start paths so a trigger that lands on the
    // completion edge still gets the full length
    if (seq_go || !st_r.start_flag) begin
      st_nxt.div = lead_len;
    end else if (step_en) begin
      st_nxt.div = step_len - 6'h01;
    end else begin
      st_nxt.div = st_r.div - 6'h01;
    end

    // Completion request flag; set wins over clear
    if (load_result) begin
      st_nxt.req_flag = 1'b1;
    end

    // Read channel
    rd_idx = 16'(s_axi_araddr >> 2);
    rd_hit = 1'b1;
    unique case (rd_idx)
      sar_adc_pkg::MODE_IDX:     rd_word = {24'h0, st_r.mode};
      // Readable anytime
      sar_adc_pkg::RESULT_IDX:   rd_word = {24'h0, result_r};
      // Reserved start bits read one
      sar_adc_pkg::START_IDX:    rd_word = {24'h0, st_r.start_flag,
                                   sar_adc_pkg::START_RSV_MASK[6:0]};
      sar_adc_pkg::IRQ_STAT_IDX: rd_word = {31'h0, st_r.req_flag};
      sar_adc_pkg::IRQ_MASK_IDX: rd_word = {31'h0, st_r.req_mask};
      sar_adc_pkg::TRIG_CFG_IDX: rd_word = {30'h0, st_r.trig_cfg};
      default: begin
        rd_word = 32'h0;
        rd_hit  = 1'b0;
      end
    endcase
    if (s_axi_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_word;
      st_nxt.rresp  = rd_hit ? sar_adc_pkg::RESP_OKAY :
                               sar_adc_pkg::RESP_SLVERR;
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register; reset values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r            <= '0;
      st_r.mode       <= sar_adc_pkg::MODE_RESET;
      st_r.start_flag <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Result holds until next completion, never reset
  always_ff @(posedge aclk) begin
    if (load_result) begin
      result_r <= seq_value;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign s_axi_awready = !st_r.aw_held;
  assign s_axi_wready  = !st_r.w_held;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;
  // Channel decode: 00xx selects nothing
  assign input_valid  = (st_r.mode[3:2] != 2'b00);
  assign input_select = st_r.mode[3:0] - sar_adc_pkg::CHAN_BASE;
  // Level interrupt, gated by enable
  assign irq = st_r.req_flag & st_r.req_mask;

endmodule

`default_nettype wire

// *** verification/sar_adc_checker.sv ***
/* Port checker of sar_adc_control, bound to every instance.
   Assumes one read in flight at a time on the register bus. */
`timescale 1ns/10ps
`default_nettype none
module sar_adc_checker #(
  parameter int ADDR_W = 18
) (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Register bus
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // Front end and interrupt
  input wire logic              input_valid,
  input wire logic [3:0]        input_select,
  input wire logic              irq
);
  //////////////////////////////////////////////////////////////////////
  logic [ADDR_W-1:0] ar_q_r; // Last read address taken
  logic [15:0]       idx;    // Its register index
  logic              hit;    // Index is mapped
  // Kept so the answer one cycle later can be judged
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ar_q_r <= s_axi_araddr;
    end
  end
  assign idx = 16'(ar_q_r >> 2);
  assign hit = idx inside {sar_adc_pkg::MODE_IDX, sar_adc_pkg::RESULT_IDX,
    sar_adc_pkg::START_IDX, sar_adc_pkg::IRQ_STAT_IDX,
    sar_adc_pkg::IRQ_MASK_IDX, sar_adc_pkg::TRIG_CFG_IDX};
  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence ar_taken_s; s_axi_arvalid && s_axi_arready; endsequence
  sequence rd_back_s; ar_taken_s ##1 s_axi_rvalid; endsequence
  sequence wr_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  reset_idle_a: assert property ($rose(aresetn) |->
    !s_axi_bvalid && !s_axi_rvalid && !irq) else $error("busy after reset");
  read_answer_a: assert property (ar_taken_s |=> s_axi_rvalid)
    else $error("read not answered");
  write_answer_a: assert property (wr_taken_s |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  resp_decode_a: assert property (rd_back_s |-> s_axi_rresp == (hit ?
    sar_adc_pkg::RESP_OKAY : sar_adc_pkg::RESP_SLVERR))
    else $error("wrong read response");
  mode_rsv_a: assert property (
    rd_back_s ##0 idx == sar_adc_pkg::MODE_IDX |->
    s_axi_rdata[5:4] == 2'h3) else $error("mode reserved bits");
  start_rsv_a: assert property (
    rd_back_s ##0 idx == sar_adc_pkg::START_IDX |->
    s_axi_rdata[6:0] == 7'h7f) else $error("start reserved bits");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  select_range_a: assert property (input_valid |-> input_select <= 4'hb)
    else $error("input select out of range");
endmodule
bind sar_adc_control sar_adc_checker #(.ADDR_W(ADDR_W)) sar_adc_checker_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .input_valid(input_valid),
  .input_select(input_select), .irq(irq));
`default_nettype wire

// *** verification/sar_adc_far_side.sv ***
/* Analog inputs and trigger source facing the converter control.
   Assumes the ladder compares within the same clock cycle. */
`timescale 1ns/10ps
`default_nettype none
module sar_adc_far_side (
  // Ladder side
  input wire logic [7:0] trial_code,
  input wire logic       input_valid,
  input wire logic [3:0] input_select,
  output logic           cmp_above,
  // Trigger side
  input wire logic       trig_level,
  output var logic       external_trigger_pin
);
  logic [7:0] lvl; // Level of the selected input, zero with none
  // Each input sits at a distinct level so a wrong mux shows
  assign lvl = input_valid ? {input_select, 4'h9} : 8'h00;
  assign cmp_above = (lvl >= trial_code);
  // Skew keeps the pin off the clock edge
  initial external_trigger_pin = 1'b0;
  always @(trig_level) external_trigger_pin <= #3 trig_level;
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
/* Self-checking bench of sar_adc_control with its far side model.
   Assumes the checker is bound in by its own file. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [1:0] resp; logic [31:0] mask; logic [31:0] data;
  } exp_t;
  localparam logic [31:0] FULL = 32'hffffffff;
  localparam logic [1:0]  OK   = sar_adc_pkg::RESP_OKAY;
  localparam int          LONG  = sar_adc_pkg::CONV_LONG_CYC;
  localparam int          SHORT = sar_adc_pkg::CONV_SHORT_CYC;
  logic        aclk = 1'b0, aresetn = 1'b0;     // Clock, reset
  logic [17:0] awaddr = 18'h0, araddr = 18'h0;  // Addresses
  logic [31:0] wdata = 32'h0;                   // Write data
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, cmp, trig_pin;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  trial;
  logic        in_valid, irq, trig_level = 1'b0;
  logic [3:0]  in_sel;
  exp_t        exp_q[$], cur;                   // Expected reads
  int          num_errors = 0, samples_checked = 0, n;
  int          seed = 32'hfa6109be;
  logic [7:0]  last_res;                        // Last good result
  logic        spd;
  always #5 aclk = ~aclk;
  sar_adc_control #(.ADDR_W(18)) sar_adc_control_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .external_trigger_pin(trig_pin),
    .cmp_above(cmp), .trial_code(trial), .input_valid(in_valid),
    .input_select(in_sel), .irq(irq));
  sar_adc_far_side sar_adc_far_side_inst (
    .trial_code(trial), .input_valid(in_valid), .input_select(in_sel),
    .cmp_above(cmp), .trig_level(trig_level),
    .external_trigger_pin(trig_pin));
  //////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [33:0] seen,
                       input logic [33:0] want);
    samples_checked++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask
  // Ready and valid are looked at on the falling edge, acted on after
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic a, w, b;
    int k;
    b = 1'b0;
    k = 0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b && k < 200) begin
      @(negedge aclk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      if (b) check("write resp", bresp, OK);
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
      k++;
    end
    if (!b) check("write done", 1'b0, 1'b1);
  endtask
  // Expected value is noted first, the monitor compares it
  task automatic rd(input logic [15:0] idx, input logic [31:0] d,
                    input logic [31:0] m, input logic [1:0] r);
    logic a, g;
    int k;
    g = 1'b0;
    k = 0;
    exp_q.push_back('{r, m, d});
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!g && k < 200) begin
      @(negedge aclk);
      a = arvalid && arready;
      g = rvalid;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
      if (g) rready <= 1'b0;
      k++;
    end
    if (!g) check("read done", 1'b0, 1'b1);
  endtask
  task automatic wait_irq(output int c);
    c = 0;
    while (irq !== 1'b1 && c < 200) begin
      @(negedge aclk);
      c++;
    end
  endtask
  // Trigger try with pin function and edge in cfg
  task automatic trig(input logic [1:0] cfg, input logic en,
                      input logic idle, input logic go);
    wr(sar_adc_pkg::MODE_IDX, 32'h06);
    trig_level <= idle;
    wr(sar_adc_pkg::TRIG_CFG_IDX, {30'h0, cfg});
    wr(sar_adc_pkg::MODE_IDX, {25'h0, en, 6'h06});
    repeat (4) @(posedge aclk);
    trig_level <= ~idle;
    repeat (8) @(posedge aclk);
    if (go) begin
      wait_irq(n);
      check("trig irq", irq, 1'b1);
      rd(sar_adc_pkg::RESULT_IDX, 32'h29, FULL, OK);
      repeat (8) @(posedge aclk);
      rd(sar_adc_pkg::START_IDX, 32'h7f, FULL, OK);
      wr(sar_adc_pkg::IRQ_STAT_IDX, 32'h1);
      last_res = 8'h29;
    end else begin
      rd(sar_adc_pkg::START_IDX, 32'h7f, FULL, OK);
    end
    $display("test trigger %h done", cfg);
  endtask
  //////////////////////////////////////////////////////////////////////
  // Monitor: every read answer meets the oldest note
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      cur = exp_q.pop_front();
      check("read", {rresp, rdata & cur.mask}, {cur.resp, cur.data});
    end
  end
  task automatic end_of_test;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #300000;
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(sar_adc_pkg::MODE_IDX, 32'h30, FULL, OK);
    rd(sar_adc_pkg::START_IDX, 32'h7f, FULL, OK);
    rd(sar_adc_pkg::RESULT_IDX, 32'h0, 32'h0, OK);
    rd(16'hffc7, 32'h0, FULL, sar_adc_pkg::RESP_SLVERR);
    wr(sar_adc_pkg::MODE_IDX, 32'h4b);
    rd(sar_adc_pkg::MODE_IDX, 32'h7b, FULL, OK);
    wr(sar_adc_pkg::START_IDX, 32'h0);
    rd(sar_adc_pkg::START_IDX, 32'h7f, FULL, OK);
    wr(sar_adc_pkg::IRQ_MASK_IDX, 32'h1);
    $display("test registers done");
    // Every input code, random speed; settings change only while idle
    for (int c = 4; c < 16; c++) begin
      spd = 1'($random(seed));
      wr(sar_adc_pkg::MODE_IDX, {24'h0, spd, 3'h0, 4'(c)});
      wr(sar_adc_pkg::START_IDX, 32'h80);
      check("select", {in_valid, in_sel}, {1'b1, 4'(c - 4)});
      rd(sar_adc_pkg::START_IDX, 32'hff, FULL, OK);
      wait_irq(n);
      // The count starts three cycles after the start flag rises
      check("length", 34'(n + 3), 34'(spd ? SHORT : LONG));
      last_res = {4'(c - 4), 4'h9};
      rd(sar_adc_pkg::RESULT_IDX, {24'h0, last_res}, FULL, OK);
      rd(sar_adc_pkg::START_IDX, 32'h7f, FULL, OK);
      rd(sar_adc_pkg::IRQ_STAT_IDX, 32'h1, FULL, OK);
      wr(sar_adc_pkg::IRQ_STAT_IDX, 32'h1);
      @(negedge aclk);
      check("irq clear", irq, 1'b0);
    end
    $display("test conversions done");
    wr(sar_adc_pkg::MODE_IDX, 32'h02);
    check("no input", in_valid, 1'b0);
    wr(sar_adc_pkg::START_IDX, 32'h80);
    repeat (8) @(posedge aclk);
    wr(sar_adc_pkg::START_IDX, 32'h0);
    rd(sar_adc_pkg::START_IDX, 32'h7f, FULL, OK);
    repeat (80) @(posedge aclk);
    check("abort irq", irq, 1'b0);
    rd(sar_adc_pkg::IRQ_STAT_IDX, 32'h0, FULL, OK);
    rd(sar_adc_pkg::RESULT_IDX, {24'h0, last_res}, FULL, OK);
    $display("test abort done");
    trig(2'h3, 1'b1, 1'b0, 1'b1);
    trig(2'h1, 1'b1, 1'b1, 1'b1);
    trig(2'h2, 1'b1, 1'b0, 1'b0);
    trig(2'h3, 1'b0, 1'b0, 1'b0);
    // Completion with the enable off: flag set, no interrupt
    wr(sar_adc_pkg::IRQ_MASK_IDX, 32'h0);
    wr(sar_adc_pkg::START_IDX, 32'h80);
    repeat (80) @(posedge aclk);
    check("masked irq", irq, 1'b0);
    rd(sar_adc_pkg::IRQ_STAT_IDX, 32'h1, FULL, OK);
    $display("test masked request done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(sar_adc_pkg::MODE_IDX, 32'h30, FULL, OK);
    $display("test second reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
